// [lsm_top.sv]
// Mode command engine and data reporting of the linear sensor unit
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`default_nettype none
`include "lsm_cfg.svh"
module lsm_top #(
	parameter int W = 16,
	parameter int FAST_CYC = `LSM_FAST_US * `LSM_CLK_MHZ,
	parameter int SLOW_CYC = `LSM_SLOW_US * `LSM_CLK_MHZ
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic adc_valid,
	input wire logic signed [W-1:0] adc_data,
	input wire logic overrange,
	input wire logic disconnect,
	input wire logic timing_input,
	input wire logic hold_release_input,
	input wire logic zero_input,
	input wire logic zero_reset_input,
	output logic sample_req,
	output logic speed_fast,
	output logic [1:0] input_type,
	output logic scale_restore,
	output logic nv_write,
	output logic [W-1:0] monitor_out
);
	lsm_pkg::lsm_state_t state;
	lsm_pkg::lsm_hold_t hold_mode;
	logic cmp_mode;
	logic mon_da;
	logic [2:0] avg_shift;
	logic is_mode_b;
	logic [15:0] in_word;
	logic [15:0] out_word;
	logic [15:0] da_word;
	logic [15:0] set_hi;
	logic [15:0] set_lo;
	logic zero_nv;
	logic [16:0] nv_count;
	logic signed [W-1:0] zero_shift;
	logic zero_q;
	logic aw_got;
	logic w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic wr_out;
	logic [15:0] wval;
	logic is_cmd;
	logic param_ok;
	logic avg_valid;
	logic signed [W-1:0] avg_data;
	logic signed [W-1:0] held;
	logic signed [W-1:0] value;
	logic [15:0] flags;
	logic [15:0] next_in_word;
	logic [31:0] cyc;

	// Byte-lane merge used by the output word and the two set-point registers
	function automatic logic [15:0] lsm_merge(input logic [15:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		lsm_merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction : lsm_merge

	// A digit is either zero (keep) or a code from 1 to top
	function automatic logic lsm_digit_ok(input logic [3:0] d, input logic [3:0] top);
		lsm_digit_ok = (d <= top);
	endfunction : lsm_digit_ok

	// Write channel: each of address and data taken once, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_got && !s_axi_bvalid;
			s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_got && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:2] > `LSM_ADDR_ZCFG >> 2) ? 2'h3 : 2'h0;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign wr_go = aw_got && w_got && !s_axi_bvalid;
	assign wr_out = wr_go && aw_addr[7:2] == `LSM_ADDR_OUT >> 2 && w_strb[1:0] != 2'h0;
	assign wval = lsm_merge(out_word, w_data, w_strb);
	assign is_cmd = wval[15:12] == `LSM_CMD_TAG;
	assign param_ok = is_mode_b ? (lsm_digit_ok(wval[15:12], 4'h2) &&
			lsm_digit_ok(wval[11:8], 4'h5)) :
		(lsm_digit_ok(wval[15:12], 4'h2) && lsm_digit_ok(wval[11:8], 4'h5) &&
			lsm_digit_ok(wval[7:4], 4'h4) && lsm_digit_ok(wval[3:0], 4'h2));

	// Software registers: output word, set points and zero configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			set_hi <= `LSM_RST_SETHI;
			set_lo <= `LSM_RST_SETLO;
			zero_nv <= 1'b0;
			out_word <= 16'h0000;
		end else if (wr_go) begin
			if (aw_addr[7:2] == `LSM_ADDR_OUT >> 2) begin
				out_word <= wval;
			end
			if (aw_addr[7:2] == `LSM_ADDR_SETHI >> 2) begin
				set_hi <= lsm_merge(set_hi, w_data, w_strb);
			end
			if (aw_addr[7:2] == `LSM_ADDR_SETLO >> 2) begin
				set_lo <= lsm_merge(set_lo, w_data, w_strb);
			end
			if (aw_addr[7:2] == `LSM_ADDR_ZCFG >> 2 && w_strb[0]) begin
				zero_nv <= w_data[0];
			end
		end
	end

	// Read channel with decode error for unmapped words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				unique case (s_axi_araddr[7:2])
					`LSM_ADDR_OUT >> 2: s_axi_rdata <= {16'h0000, out_word};
					`LSM_ADDR_IN >> 2: s_axi_rdata <= {16'h0000, in_word};
					`LSM_ADDR_MODE >> 2: s_axi_rdata <= {16'h0000, 2'h0, state, speed_fast,
						avg_shift, mon_da, hold_mode, input_type, cmp_mode};
					`LSM_ADDR_SETHI >> 2: s_axi_rdata <= {16'h0000, set_hi};
					`LSM_ADDR_SETLO >> 2: s_axi_rdata <= {16'h0000, set_lo};
					`LSM_ADDR_ZCFG >> 2: s_axi_rdata <= {14'h0000, nv_count, zero_nv};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h3;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Command engine: code, then parameter; modes persist
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= lsm_pkg::LSM_ST_DATA;
			is_mode_b <= 1'b0;
			cmp_mode <= 1'b0;
			hold_mode <= lsm_pkg::LSM_HOLD_NORMAL;
			input_type <= 2'h0;
			mon_da <= 1'b0;
			speed_fast <= 1'b0;
			avg_shift <= `LSM_RST_AVG;
			scale_restore <= 1'b0;
			da_word <= 16'h0000;
		end else begin
			scale_restore <= 1'b0;
			if (wr_out) begin
				if (is_cmd) begin
					is_mode_b <= wval == `LSM_CMD_B;
					state <= (wval == `LSM_CMD_A || wval == `LSM_CMD_B) ?
						lsm_pkg::LSM_ST_PARAM : lsm_pkg::LSM_ST_ECHO;
				end else if (state == lsm_pkg::LSM_ST_PARAM) begin
					state <= lsm_pkg::LSM_ST_ECHO;
					if (param_ok && is_mode_b) begin
						if (wval[15:12] != 4'h0) speed_fast <= wval[15:12] == 4'h1;
						if (wval[11:8] != 4'h0) avg_shift <= 3'(wval[11:8] - 4'h1);
					end else if (param_ok) begin
						if (wval[15:12] != 4'h0) cmp_mode <= wval[15:12] == 4'h2;
						if (wval[11:8] != 4'h0) hold_mode <= lsm_pkg::lsm_hold_t'(3'(wval[11:8] - 4'h1));
						if (wval[7:4] != 4'h0) input_type <= 2'(wval[7:4] - 4'h1);
						if (wval[7:4] != 4'h0 && 2'(wval[7:4] - 4'h1) != input_type) begin
							scale_restore <= 1'b1;
						end
						if (wval[3:0] != 4'h0) mon_da <= wval[3:0] == 4'h2;
					end
				end else begin
					state <= lsm_pkg::LSM_ST_DATA;
					da_word <= wval; // Only non-command words set the D/A level
				end
			end
		end
	end

	// Sample request divider; rate follows the speed choice
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc <= 32'h00000000;
			sample_req <= 1'b0;
		end else begin
			sample_req <= cyc == 32'h00000000;
			cyc <= (cyc == 32'h00000000) ? 32'(speed_fast ? FAST_CYC - 1 : SLOW_CYC - 1) :
				cyc - 32'h00000001;
		end
	end

	lsm_avg #(.W(W)) u_avg (
		.aclk(aclk),
		.aresetn(aresetn),
		.shift(avg_shift),
		.in_valid(adc_valid),
		.in_data(adc_data),
		.out_valid(avg_valid),
		.out_data(avg_data)
	);

	lsm_hold #(.W(W)) u_hold (
		.aclk(aclk),
		.aresetn(aresetn),
		.mode(hold_mode),
		.timing(timing_input),
		.release_in(hold_release_input),
		.live_valid(avg_valid),
		.live(avg_data),
		.value(held)
	);

	// Zero shift: register is volatile and cleared by reset; nonvolatile
	// captures are counted and refused once worn out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zero_q <= 1'b0;
			zero_shift <= '0;
			nv_count <= 17'h00000;
			nv_write <= 1'b0;
		end else begin
			zero_q <= zero_input;
			nv_write <= 1'b0;
			if (scale_restore || zero_reset_input) begin
				zero_shift <= '0;
			end else if (zero_input && !zero_q && (!zero_nv || nv_count < 17'(`LSM_NV_LIMIT))) begin
				zero_shift <= held;
				if (zero_nv) begin
					nv_write <= 1'b1;
					nv_count <= nv_count + 17'h00001;
				end
			end
		end
	end

	assign value = W'(held - zero_shift);

	// Comparison and fault flags
	always_comb begin
		flags = 16'h0000;
		flags[`LSM_BIT_HI] = value > $signed(set_hi);
		flags[`LSM_BIT_LO] = value < $signed(set_lo);
		flags[`LSM_BIT_PASS] = !flags[`LSM_BIT_HI] && !flags[`LSM_BIT_LO];
		flags[`LSM_BIT_OVR] = overrange;
		flags[`LSM_BIT_DISC] = disconnect;
	end

	// Input word: answer during a command, else data of the active mode
	always_comb begin
		next_in_word = in_word;
		if (wr_out && is_cmd) begin
			next_in_word = (wval == `LSM_CMD_A || wval == `LSM_CMD_B) ? wval :
				`LSM_ERR_RESP;
		end else if (wr_out && state == lsm_pkg::LSM_ST_PARAM) begin
			next_in_word = param_ok ? wval : `LSM_ERR_RESP;
		end else if (state == lsm_pkg::LSM_ST_DATA && !wr_out) begin
			if (cmp_mode) begin
				next_in_word = flags;
			end else if (overrange || disconnect) begin
				next_in_word = `LSM_OVR_CODE;
			end else begin
				next_in_word = 16'(value);
			end
		end
	end

	// Input word and monitor output registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_word <= 16'h0000;
			monitor_out <= '0;
		end else begin
			in_word <= next_in_word;
			if (!mon_da) begin
				monitor_out <= value;
			end else if ($signed(da_word) > $signed(`LSM_DA_MAX)) begin
				monitor_out <= W'(`LSM_DA_MAX);
			end else if ($signed(da_word) < $signed(`LSM_DA_MIN)) begin
				monitor_out <= W'(`LSM_DA_MIN);
			end else begin
				monitor_out <= W'(da_word); // Zero word gives 0 V
			end
		end
	end

	chk_meas_report: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == lsm_pkg::LSM_ST_DATA && !cmp_mode && !overrange && !disconnect && !wr_out)
		|=> in_word == 16'($past(value)))
		else $error("measurement data not reported");
	chk_cmp_high: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == lsm_pkg::LSM_ST_DATA && cmp_mode && !wr_out && value > $signed(set_hi))
		|=> (in_word[`LSM_BIT_HI] && !in_word[`LSM_BIT_PASS]))
		else $error("high flag wrong");
	chk_fault_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == lsm_pkg::LSM_ST_DATA && !wr_out && (overrange || disconnect))
		|=> (in_word == `LSM_OVR_CODE || in_word[`LSM_BIT_OVR] || in_word[`LSM_BIT_DISC]))
		else $error("fault not flagged");
	chk_reset_meas: assert property (@(posedge aclk)
		!aresetn |=> (!cmp_mode && hold_mode == lsm_pkg::LSM_HOLD_NORMAL))
		else $error("reset mode wrong");
	chk_reset_avg: assert property (@(posedge aclk)
		!aresetn |=> (avg_shift == 3'h2 && !speed_fast && input_type == 2'h0))
		else $error("reset average or speed wrong");
	chk_cmd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_out && wval == `LSM_CMD_A) |=> (in_word == `LSM_CMD_A
		&& state == lsm_pkg::LSM_ST_PARAM))
		else $error("command not answered");
	chk_param_echo: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_out && !is_cmd && state == lsm_pkg::LSM_ST_PARAM && param_ok)
		|=> in_word == $past(wval) ##1 in_word == $past(in_word))
		else $error("parameter not echoed");
	chk_type_restore: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(input_type) |-> scale_restore ##1 zero_shift == '0)
		else $error("type change did not restore defaults");
	chk_cmd_not_da: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_out && is_cmd) |=> $stable(da_word))
		else $error("command reached the D/A level");
	chk_da_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(mon_da && da_word == 16'h0000) |=> monitor_out == '0)
		else $error("zero word not 0 V");

	cov_mode_a: cover property (@(posedge aclk) disable iff (!aresetn)
		state == lsm_pkg::LSM_ST_PARAM && !is_mode_b && wr_out && param_ok);
	cov_mode_b: cover property (@(posedge aclk) disable iff (!aresetn)
		state == lsm_pkg::LSM_ST_PARAM && is_mode_b && wr_out && param_ok);
	cov_cmp_pass: cover property (@(posedge aclk) disable iff (!aresetn)
		cmp_mode && in_word == 16'h0004);
endmodule : lsm_top
`default_nettype wire

// [lsm_cfg.svh]
// Constants of the sensor mode and command unit
`ifndef LSM_CFG_SVH
`define LSM_CFG_SVH
`define LSM_ADDR_OUT 8'h00
`define LSM_ADDR_IN 8'h04
`define LSM_ADDR_MODE 8'h08
`define LSM_ADDR_SETHI 8'h0C
`define LSM_ADDR_SETLO 8'h10
`define LSM_ADDR_ZCFG 8'h14
`define LSM_CMD_A 16'hC000
`define LSM_CMD_B 16'hC200
`define LSM_CMD_TAG 4'hC
`define LSM_ERR_RESP 16'hE000
`define LSM_OVR_CODE 16'hB000
`define LSM_BIT_LO 1
`define LSM_BIT_PASS 2
`define LSM_BIT_HI 3
`define LSM_BIT_OVR 8
`define LSM_BIT_DISC 9
`define LSM_DA_MAX 16'h270F
`define LSM_DA_MIN 16'hD8F1
`define LSM_RST_SETHI 16'h0000
`define LSM_RST_SETLO 16'h0000
`define LSM_RST_AVG 3'h2
`define LSM_CLK_MHZ 25
`define LSM_FAST_US 1000
`define LSM_SLOW_US 4000
`define LSM_NV_LIMIT 100000
`endif

// [lsm_pkg.sv]
// Types of the sensor mode and command unit
`default_nettype none
package lsm_pkg;
	typedef enum logic [2:0] {
		LSM_HOLD_NORMAL = 3'h0,
		LSM_HOLD_SAMPLE = 3'h1,
		LSM_HOLD_MAX = 3'h2,
		LSM_HOLD_MIN = 3'h3,
		LSM_HOLD_P2P = 3'h4
	} lsm_hold_t;
	typedef enum logic [2:0] {
		LSM_ST_DATA = 3'h1,
		LSM_ST_PARAM = 3'h2,
		LSM_ST_ECHO = 3'h4
	} lsm_state_t;
endpackage : lsm_pkg
`default_nettype wire

// [lsm_avg.sv]
// Running block average over 1, 2, 4, 8 or 16 samples
`default_nettype none
module lsm_avg #(
	parameter int W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] shift,
	input wire logic in_valid,
	input wire logic signed [W-1:0] in_data,
	output logic out_valid,
	output logic signed [W-1:0] out_data
);
	logic signed [W+3:0] acc;
	logic [4:0] cnt;
	logic [4:0] last;
	logic signed [W+3:0] sum;

	assign last = 5'((5'h01 << shift) - 5'h01);
	assign sum = acc + (W+4)'(in_data);

	// Average completes when the chosen count is reached
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= '0;
			cnt <= 5'h00;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			out_valid <= 1'b0;
			if (in_valid) begin
				if (cnt >= last) begin
					out_data <= W'(sum >>> shift);
					out_valid <= 1'b1;
					acc <= '0;
					cnt <= 5'h00;
				end else begin
					acc <= sum;
					cnt <= cnt + 5'h01;
				end
			end
		end
	end
endmodule : lsm_avg
`default_nettype wire

// [lsm_hold.sv]
// Timing hold: sampling, maximum, minimum and peak-to-peak capture
`default_nettype none
module lsm_hold #(
	parameter int W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire lsm_pkg::lsm_hold_t mode,
	input wire logic timing,
	input wire logic release_in,
	input wire logic live_valid,
	input wire logic signed [W-1:0] live,
	output logic signed [W-1:0] value
);
	logic timing_q;
	logic have;
	logic signed [W-1:0] live_q;
	logic signed [W-1:0] held;
	logic signed [W-1:0] hi;
	logic signed [W-1:0] lo;

	// Remember previous timing level for the rising instant
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timing_q <= 1'b0;
			live_q <= '0;
		end else begin
			timing_q <= timing;
			if (live_valid) begin
				live_q <= live;
			end
		end
	end

	// Capture; release drops the hold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have <= 1'b0;
			held <= '0;
			hi <= '0;
			lo <= '0;
		end else if (release_in || mode == lsm_pkg::LSM_HOLD_NORMAL) begin
			have <= 1'b0;
		end else if (mode == lsm_pkg::LSM_HOLD_SAMPLE) begin
			if (timing && !timing_q) begin
				held <= live_q;
				have <= 1'b1;
			end
		end else if (timing && live_valid) begin
			have <= 1'b1;
			hi <= (!have || live > hi) ? live : hi;
			lo <= (!have || live < lo) ? live : lo;
		end
	end

	// Present the held figure, or live data while nothing is held
	always_comb begin
		if (!have) begin
			value = live_q;
		end else begin
			unique case (mode)
				lsm_pkg::LSM_HOLD_MAX: value = hi;
				lsm_pkg::LSM_HOLD_MIN: value = lo;
				lsm_pkg::LSM_HOLD_P2P: value = W'(hi - lo);
				default: value = held;
			endcase
		end
	end

	chk_release_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		release_in |=> !have)
		else $error("hold survived release");
	chk_sample_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == lsm_pkg::LSM_HOLD_SAMPLE && timing && !timing_q && !release_in)
		|=> (have && held == $past(live_q)))
		else $error("sampling hold missed the timing edge");
endmodule : lsm_hold
`default_nettype wire

// [lsm_sensor_model.sv]
// Sensor front-end model answering the unit's sample requests
`default_nettype none
module lsm_sensor_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sample_req,
	input wire logic signed [15:0] level,
	output logic adc_valid,
	output logic signed [15:0] adc_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// One conversion per request; data lines scrambled outside a sample
	always_ff @(posedge aclk) begin
		adc_valid <= aresetn && sample_req;
		adc_data <= (aresetn && sample_req) ? level : ~level; // Stale value never reused
	end
endmodule : lsm_sensor_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the sensor mode and command unit
`default_nettype none
`include "lsm_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int fast_cyc = 8;
	localparam logic [31:0] full = 32'hFFFFFFFF;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic signed [15:0] level = 16'h0000;
	logic ovr = 1'b0, disc = 1'b0, timing = 1'b0, hrel = 1'b0, zin = 1'b0, zrst = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, adc_valid, sample_req, speed_fast;
	logic scale_restore, nv_write;
	logic [1:0] bresp, rresp, input_type;
	logic [31:0] rdata;
	logic signed [15:0] adc_data;
	logic [15:0] monitor_out;
	int bad_count = 0, n_tests = 0, restores = 0, nv_writes = 0;
	lsm_top #(.W(16), .FAST_CYC(fast_cyc), .SLOW_CYC(20)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.adc_valid(adc_valid), .adc_data(adc_data), .overrange(ovr), .disconnect(disc),
		.timing_input(timing), .hold_release_input(hrel), .zero_input(zin),
		.zero_reset_input(zrst), .sample_req(sample_req), .speed_fast(speed_fast),
		.input_type(input_type), .scale_restore(scale_restore), .nv_write(nv_write),
		.monitor_out(monitor_out));
	lsm_sensor_model i_sensor (.aclk(aclk), .aresetn(aresetn), .sample_req(sample_req),
		.level(level), .adc_valid(adc_valid), .adc_data(adc_data));
	// Free-running bus clock
	always #20 aclk = ~aclk;
	// Restore and nonvolatile write pulses counted at the edge that samples them
	always @(posedge aclk) begin
		if (scale_restore === 1'b1) restores++;
		if (nv_write === 1'b1) nv_writes++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Write cycle; bready stays high so the answer is taken at once
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && t < 50);
		chk(bvalid, 1'b1);
		chk(bresp, 2'h0);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && t < 50);
		d = rdata;
		r = rresp;
	endtask : axr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(d & m, e);
	endtask : rdchk
	// Waits for n sample requests, bounded, then lets the pipeline drain
	task automatic settle(input int n);
		int c;
		c = 0;
		repeat (n * 120) begin
			@(posedge aclk);
			if (sample_req === 1'b1) c++;
			if (c >= n) break;
		end
		repeat (6) @(posedge aclk);
	endtask : settle
	task automatic cmd(input logic [31:0] code, input logic [31:0] prm);
		axw(`LSM_ADDR_OUT, code);
		axw(`LSM_ADDR_OUT, prm);
		axw(`LSM_ADDR_OUT, 32'h00000000);
	endtask : cmd
	task automatic t_flag(input logic [15:0] lv, input logic o, input logic dc,
		input logic [31:0] m, input logic [31:0] e);
		level <= lv;
		ovr <= o;
		disc <= dc;
		settle(10);
		rdchk(`LSM_ADDR_IN, m, e);
	endtask : t_flag
	task automatic da(input logic [31:0] w, input logic [15:0] e);
		axw(`LSM_ADDR_OUT, w);
		repeat (3) @(posedge aclk);
		chk(monitor_out, e);
	endtask : da
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		chk(speed_fast, 1'b0);
		chk(input_type, 2'h0);
		rdchk(`LSM_ADDR_MODE, full, 32'h00000900);
		axr(8'h20, d, r);
		chk(r, 2'h3);
		chk(d, 32'h00000000);
		$display("test reset defaults done");
	endtask : t_reset
	task automatic t_cmd;
		t_flag(16'h0123, 1'b0, 1'b0, full, 32'h00000123);
		chk(monitor_out, 16'h0123);
		axw(`LSM_ADDR_OUT, 32'h0000C000);
		rdchk(`LSM_ADDR_IN, full, 32'h0000C000);
		axw(`LSM_ADDR_OUT, 32'h00002040);
		rdchk(`LSM_ADDR_IN, full, 32'h00002040);
		chk(input_type, 2'h3);
		chk(restores, 32'h1);
		axw(`LSM_ADDR_OUT, 32'h00000000);
		axw(`LSM_ADDR_SETHI, 32'h00000200);
		axw(`LSM_ADDR_SETLO, 32'h00000100);
		rdchk(`LSM_ADDR_MODE, full, 32'h00000907);
		t_flag(16'h0150, 1'b0, 1'b0, 32'h0000000E, 32'h00000004);
		t_flag(16'h0300, 1'b0, 1'b0, 32'h0000000E, 32'h00000008);
		t_flag(16'h0050, 1'b0, 1'b0, 32'h0000000E, 32'h00000002);
		t_flag(16'h0150, 1'b1, 1'b0, 32'h00000300, 32'h00000100);
		t_flag(16'h0150, 1'b0, 1'b1, 32'h00000300, 32'h00000200);
		$display("test commands and comparison done");
	endtask : t_cmd
	task automatic t_speed;
		int c;
		disc <= 1'b0;
		cmd(32'h0000C200, 32'h00001100);
		chk(speed_fast, 1'b1);
		rdchk(`LSM_ADDR_MODE, full, 32'h00000C07);
		c = 0;
		while (sample_req !== 1'b1 && c < 100) begin
			@(posedge aclk);
			c++;
		end
		c = 0;
		do begin
			@(posedge aclk);
			c++;
		end while (sample_req !== 1'b1 && c < 100);
		chk(c, fast_cyc);
		$display("test sampling speed done");
	endtask : t_speed
	task automatic t_da;
		cmd(32'h0000C000, 32'h00001002);
		chk(monitor_out, 16'h0000);
		chk(restores, 32'h1);
		da(32'h00001234, 16'h1234);
		da(32'h00003000, `LSM_DA_MAX);
		da(32'h0000C5FF, `LSM_DA_MAX);
		rdchk(`LSM_ADDR_IN, full, {16'h0000, `LSM_ERR_RESP});
		da(32'h00000000, 16'h0000);
		t_flag(16'h0123, 1'b0, 1'b0, full, 32'h00000123);
		t_flag(16'h0123, 1'b1, 1'b0, full, {16'h0000, `LSM_OVR_CODE});
		$display("test monitor output done");
	endtask : t_da
	task automatic t_hold;
		ovr <= 1'b0;
		cmd(32'h0000C000, 32'h00000301);
		rdchk(`LSM_ADDR_MODE, 32'h00000038, 32'h00000010);
		level <= 16'h0050;
		settle(2);
		timing <= 1'b1;
		settle(4);
		level <= 16'h0020;
		settle(4);
		timing <= 1'b0;
		level <= 16'h0010;
		settle(4);
		rdchk(`LSM_ADDR_IN, full, 32'h00000050);
		hrel <= 1'b1;
		settle(2);
		hrel <= 1'b0;
		settle(4);
		rdchk(`LSM_ADDR_IN, full, 32'h00000010);
		cmd(32'h0000C000, 32'h00000200);
		rdchk(`LSM_ADDR_MODE, 32'h00000038, 32'h00000008);
		level <= 16'h0040;
		settle(2);
		timing <= 1'b1;
		settle(2);
		timing <= 1'b0;
		level <= 16'h0030;
		settle(4);
		rdchk(`LSM_ADDR_IN, full, 32'h00000040);
		$display("test timing hold done");
	endtask : t_hold
	// Zero capture into the nonvolatile copy, then zero reset
	task automatic t_zero;
		ovr <= 1'b0;
		level <= 16'h0077;
		axw(`LSM_ADDR_ZCFG, 32'h00000001);
		settle(4);
		zin <= 1'b1;
		settle(2);
		zin <= 1'b0;
		rdchk(`LSM_ADDR_IN, full, 32'h00000000);
		chk(nv_writes, 32'h1);
		rdchk(`LSM_ADDR_ZCFG, full, 32'h00000003);
		zrst <= 1'b1;
		settle(2);
		zrst <= 1'b0;
		settle(2);
		rdchk(`LSM_ADDR_IN, full, 32'h00000077);
		$display("test zero shift done");
	endtask : t_zero
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results
	// Main sequence after six reset cycles
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_cmd;
		t_speed;
		t_da;
		t_zero;
		t_hold;
		results;
	end
	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		results;
	end
endmodule : tb_top
`default_nettype wire
